// ==== hw/plld_top.sv ====
// Lock detector and charge-pump output masking for the phase detector.
// Assumes config bits come from the serial port logic on the same clock,
// detector up/down pulses are same-clock, reference and VCO edges are pins.
// Pin pulses must stay high and low two cycles or the synchroniser drops them.
// The ring oscillator is a divider, so window widths are whole clock cycles.
//
// How it works
// - Up enable clear masks up pulse; down enable clear masks down pulse.
// - Both enables clear put the pump in high impedance; all else keeps running.
// - Lock detection runs only while the lock-detect enable bit is set.
// - A one-shot window surrounds each reference edge; VCO edges are judged against it.
// - Source bit clear gives a fixed 10 ns window; set gives ring-oscillator window.
// - In digital mode a 2-bit field configures the ring oscillator.
// - In digital mode a 2-bit field sets window length in ring periods.
// - Test bit set and output select 0111 put the ring oscillator on aux pin two.
// - Ring-oscillator test mode suspends lock detection.
// - Lock declared once consecutive in-window arrivals reach the 10-bit count.
// - Declared lock sets the lock flag.
// - One arrival outside the window clears the lock flag at once.
// - Lock flag is read-only, offered to the serial port for reads.
// - Force bit set drives the lock flag continuously onto the shared pin.
// - Share mode shows lock flag, swaps to serial data during reads.
`timescale 1ns/10ps
module plld_top (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire plld_pkg::plld_cfg_type cfg_i,
	input wire logic ref_edge_i,
	input wire logic vco_edge_i,
	input wire logic pfd_up_i,
	input wire logic pfd_dn_i,
	input wire logic serial_read_i,
	input wire logic serial_data_i,
	input wire logic aux_two_other_i,
	output logic pump_up_o,
	output logic pump_dn_o,
	output logic pump_hiz_o,
	output logic locked_flag_o,
	output logic lock_or_readback_pin_o,
	output logic aux_output_pin_two_o
);
	// Retimed edge pulses, ring outputs and window timing
	logic ref_rise;
	logic vco_rise;
	logic ro_osc;
	logic ro_tick;
	logic ro_run;
	logic det_on;
	logic unit;
	logic [plld_pkg::TMR_W-1:0] win_len;

	// Window judge state
	plld_pkg::plld_win_state_type win_state_reg;
	plld_pkg::plld_win_state_type win_state_next;
	logic [plld_pkg::TMR_W-1:0] tmr_reg;
	logic [plld_pkg::TMR_W-1:0] tmr_next;
	logic hit;
	logic miss;

	// Lock state
	logic [plld_pkg::LOCK_CNT_W-1:0] hits_reg;
	logic [plld_pkg::LOCK_CNT_W-1:0] hits_next;
	logic locked_reg;
	logic locked_next;

	// Output registers
	logic pump_up_reg;
	logic pump_up_next;
	logic pump_dn_reg;
	logic pump_dn_next;
	logic pump_hiz_reg;
	logic pump_hiz_next;
	logic ld_pin_reg;
	logic ld_pin_next;
	logic aux_two_reg;
	logic aux_two_next;

	// Edges from the pins are retimed before any decision
	plld_sync u_ref_sync (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.async_i(ref_edge_i),
		.rise_o(ref_rise)
	);

	// Same latency on the VCO path, so arrival offsets survive retiming
	plld_sync u_vco_sync (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.async_i(vco_edge_i),
		.rise_o(vco_rise)
	);

	// Oscillator runs in digital window mode or in test mode, so it is visible on the pin
	assign ro_run = cfg_i.win_digital | cfg_i.ro_test;

	// Ring sets the digital window's time unit and feeds aux pin two
	plld_ring_osc u_ring_osc (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.run_i(ro_run),
		.cfg_i(cfg_i.ro_cfg),
		.osc_o(ro_osc),
		.tick_o(ro_tick)
	);

	// Detection gate; test mode wins over the enable
	assign det_on = cfg_i.lock_det_en & ~cfg_i.ro_test;

	// Window unit and length: clock cycles for analog, ring periods for digital
	always_comb begin
		// Analog mode counts clock cycles; its fixed width is one of them
		unit = cfg_i.win_digital ? ro_tick : 1'b1;
		win_len = plld_pkg::WIN_ANALOG;
		if (cfg_i.win_digital) begin
			unique case (cfg_i.win_dur)
				2'h0: win_len = plld_pkg::DUR_0;
				2'h1: win_len = plld_pkg::DUR_1;
				2'h2: win_len = plld_pkg::DUR_2;
				2'h3: win_len = plld_pkg::DUR_3;
			endcase
		end
	end

	// Window judge. The window straddles the reference edge: a VCO edge first
	// waits one window for its reference, a reference edge first waits one
	// window for its VCO edge. Expiry or a second edge of the same kind is a miss.
	always_comb begin
		win_state_next = win_state_reg;
		tmr_next = tmr_reg;
		hit = 1'b0;
		miss = 1'b0;
		if (!det_on) begin
			// Disabled or in ring test: window closed, no verdicts
			win_state_next = plld_pkg::WIN_IDLE;
			tmr_next = plld_pkg::TMR_ZERO;
		end else begin
			unique case (win_state_reg)
				plld_pkg::WIN_IDLE: begin
					// Coincident edges are a hit at once; a lone edge opens a window
					if (ref_rise && vco_rise) begin
						hit = 1'b1;
					end else if (ref_rise) begin
						win_state_next = plld_pkg::WIN_REF_OPEN;
						tmr_next = win_len;
					end else if (vco_rise) begin
						win_state_next = plld_pkg::WIN_VCO_WAIT;
						tmr_next = win_len;
					end
				end
				plld_pkg::WIN_REF_OPEN: begin
					// Reference came first; the VCO edge must follow inside the window
					if (vco_rise) begin
						hit = 1'b1;
						win_state_next = plld_pkg::WIN_IDLE;
						tmr_next = plld_pkg::TMR_ZERO;
					end else if (ref_rise) begin
						// Second reference with no VCO edge; the window reopens for it
						miss = 1'b1;
						tmr_next = win_len;
					end else if (unit && tmr_reg <= plld_pkg::TMR_ONE) begin
						miss = 1'b1;
						win_state_next = plld_pkg::WIN_IDLE;
						tmr_next = plld_pkg::TMR_ZERO;
					end else if (unit) begin
						tmr_next = tmr_reg - plld_pkg::TMR_ONE;
					end
				end
				plld_pkg::WIN_VCO_WAIT: begin
					// VCO came first; the reference must follow inside the window
					if (ref_rise) begin
						hit = 1'b1;
						win_state_next = plld_pkg::WIN_IDLE;
						tmr_next = plld_pkg::TMR_ZERO;
					end else if (vco_rise) begin
						// Second VCO edge with no reference; the window reopens for it
						miss = 1'b1;
						tmr_next = win_len;
					end else if (unit && tmr_reg <= plld_pkg::TMR_ONE) begin
						miss = 1'b1;
						win_state_next = plld_pkg::WIN_IDLE;
						tmr_next = plld_pkg::TMR_ZERO;
					end else if (unit) begin
						tmr_next = tmr_reg - plld_pkg::TMR_ONE;
					end
				end
				default: begin
					// Unused code, back to idle
					win_state_next = plld_pkg::WIN_IDLE;
					tmr_next = plld_pkg::TMR_ZERO;
				end
			endcase
		end
	end

	// Window state registers
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			win_state_reg <= plld_pkg::WIN_IDLE;
			tmr_reg <= plld_pkg::TMR_ZERO;
		end else begin
			win_state_reg <= win_state_next;
			tmr_reg <= tmr_next;
		end
	end

	// Consecutive hit counter; a miss or a disabled detector restarts it from zero
	always_comb begin
		hits_next = hits_reg;
		if (!det_on) begin
			hits_next = plld_pkg::LOCK_CNT_ZERO;
		end else if (miss) begin
			hits_next = plld_pkg::LOCK_CNT_ZERO;
		end else if (hit && hits_reg < cfg_i.lock_count) begin
			// Saturates at the programmed count so a long lock never wraps
			hits_next = hits_reg + plld_pkg::LOCK_CNT_ONE;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			hits_reg <= plld_pkg::LOCK_CNT_ZERO;
		end else begin
			hits_reg <= hits_next;
		end
	end

	// Lock flag: set once the count is reached, dropped by a single miss.
	// A miss always beats the count; a count of zero locks as soon as enabled.
	always_comb begin
		locked_next = locked_reg;
		if (!det_on) begin
			locked_next = 1'b0;
		end else if (miss) begin
			locked_next = 1'b0;
		end else if (hits_next >= cfg_i.lock_count) begin
			locked_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			locked_reg <= 1'b0;
		end else begin
			locked_reg <= locked_next;
		end
	end

	// Pump masking; a cleared enable gates only the pulse, the detector keeps running
	always_comb begin
		pump_up_next = pfd_up_i & cfg_i.up_en;
		pump_dn_next = pfd_dn_i & cfg_i.dn_en;
		pump_hiz_next = ~cfg_i.up_en & ~cfg_i.dn_en;
	end

	// Pump controls come off flip-flops, so an enable change never glitches them
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			pump_up_reg <= 1'b0;
			pump_dn_reg <= 1'b0;
			pump_hiz_reg <= 1'b0;
		end else begin
			pump_up_reg <= pump_up_next;
			pump_dn_reg <= pump_dn_next;
			pump_hiz_reg <= pump_hiz_next;
		end
	end

	// Shared pin: force beats share; share lends the pin to serial data during a read.
	// Aux pin two shows the ring only with the test bit and the matching select.
	always_comb begin
		if (cfg_i.lock_pin_force) begin
			ld_pin_next = locked_reg;
		end else if (cfg_i.lock_pin_share && !serial_read_i) begin
			ld_pin_next = locked_reg;
		end else begin
			// No force and no share, or a read in progress: serial data owns the pin
			ld_pin_next = serial_data_i;
		end
		if (cfg_i.ro_test && cfg_i.out_sel == plld_pkg::OUT_SEL_AUX_OSC) begin
			aux_two_next = ro_osc;
		end else begin
			aux_two_next = aux_two_other_i;
		end
	end

	// Pin registers; the flag reaches the pin one cycle after it moves
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ld_pin_reg <= 1'b0;
			aux_two_reg <= 1'b0;
		end else begin
			ld_pin_reg <= ld_pin_next;
			aux_two_reg <= aux_two_next;
		end
	end

	// Every output comes straight off a register.
	// Flag is only ever driven out, never written from outside
	assign locked_flag_o = locked_reg;
	assign pump_up_o = pump_up_reg;
	assign pump_dn_o = pump_dn_reg;
	assign pump_hiz_o = pump_hiz_reg;
	assign lock_or_readback_pin_o = ld_pin_reg;
	assign aux_output_pin_two_o = aux_two_reg;
endmodule : plld_top

// ==== hw/plld_pkg.sv ====
// Package for the lock detector: config carrier, field widths, timing constants.
// Assumes a single 100 MHz clock domain in every user of this package.
package plld_pkg;
	// Clock and window timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int ANALOG_WIN_NS = 10;
	localparam int ANALOG_WIN_CYC_RAW = (ANALOG_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ANALOG_WIN_CYC = (ANALOG_WIN_CYC_RAW < 1) ? 1 : ANALOG_WIN_CYC_RAW;
	// Window timer width covers the longest digital window in ring periods
	localparam int TMR_W = 4;
	localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
	localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;
	localparam logic [TMR_W-1:0] WIN_ANALOG = TMR_W'(ANALOG_WIN_CYC);
	// Ring oscillator half period in clock cycles, per 2-bit config code
	localparam int RO_CNT_W = 3;
	localparam logic [RO_CNT_W-1:0] RO_CNT_ZERO = 3'h0;
	localparam logic [RO_CNT_W-1:0] RO_CNT_ONE = 3'h1;
	localparam logic [RO_CNT_W-1:0] RO_HALF_0 = 3'h1;
	localparam logic [RO_CNT_W-1:0] RO_HALF_1 = 3'h2;
	localparam logic [RO_CNT_W-1:0] RO_HALF_2 = 3'h3;
	localparam logic [RO_CNT_W-1:0] RO_HALF_3 = 3'h4;
	// Digital window length in ring periods, per 2-bit duration code
	localparam logic [TMR_W-1:0] DUR_0 = 4'h2;
	localparam logic [TMR_W-1:0] DUR_1 = 4'h4;
	localparam logic [TMR_W-1:0] DUR_2 = 4'h6;
	localparam logic [TMR_W-1:0] DUR_3 = 4'h8;
	// Lock count and output selection
	localparam int LOCK_CNT_W = 10;
	localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_ZERO = 10'h000;
	localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_ONE = 10'h001;
	localparam int OUT_SEL_W = 4;
	localparam logic [OUT_SEL_W-1:0] OUT_SEL_AUX_OSC = 4'h7;
	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;

	// Configuration bits held by the serial control port outside this block
	typedef struct packed {
		logic up_en;
		logic dn_en;
		logic lock_det_en;
		logic win_digital;
		logic [1:0] ro_cfg;
		logic [1:0] win_dur;
		logic ro_test;
		logic [OUT_SEL_W-1:0] out_sel;
		logic [LOCK_CNT_W-1:0] lock_count;
		logic lock_pin_force;
		logic lock_pin_share;
	} plld_cfg_type;

	// Gray codes: idle reaches either waiting state by a single bit
	typedef enum logic [1:0] {
		WIN_IDLE = 2'h0,
		WIN_REF_OPEN = 2'h1,
		WIN_VCO_WAIT = 2'h2
	} plld_win_state_type;
endpackage : plld_pkg

// ==== hw/plld_sync.sv ====
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes the input is asynchronous to ref_clk_i.
`timescale 1ns/10ps
module plld_sync (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic async_i,
	output logic rise_o
);
	logic [plld_pkg::SYNC_STAGES-1:0] stage_reg;
	logic [plld_pkg::SYNC_STAGES-1:0] stage_next;
	logic level_reg;
	logic level_next;
	logic rise_reg;
	logic rise_next;

	// Level only moves once stages two and three agree; stage one is not looked at
	always_comb begin
		stage_next = {stage_reg[plld_pkg::SYNC_STAGES-2:0], async_i};
		level_next = level_reg;
		if (stage_reg[plld_pkg::SYNC_STAGES-2] == stage_reg[plld_pkg::SYNC_STAGES-1]) begin
			level_next = stage_reg[plld_pkg::SYNC_STAGES-1];
		end
		rise_next = level_next & ~level_reg;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			stage_reg <= '0;
			level_reg <= 1'b0;
			rise_reg <= 1'b0;
		end else begin
			stage_reg <= stage_next;
			level_reg <= level_next;
			rise_reg <= rise_next;
		end
	end

	assign rise_o = rise_reg;
endmodule : plld_sync

// ==== hw/plld_ring_osc.sv ====
// Ring oscillator model: a divider off ref_clk_i giving a level and a period tick.
// Assumes enable is a same-clock level; frequency set by a 2-bit config code.
`timescale 1ns/10ps
module plld_ring_osc (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic run_i,
	input wire logic [1:0] cfg_i,
	output logic osc_o,
	output logic tick_o
);
	logic [plld_pkg::RO_CNT_W-1:0] cnt_reg;
	logic [plld_pkg::RO_CNT_W-1:0] cnt_next;
	logic [plld_pkg::RO_CNT_W-1:0] half;
	logic osc_reg;
	logic osc_next;
	logic tick_reg;
	logic tick_next;

	// Half period per config code; tick once per full period on the falling half
	always_comb begin
		unique case (cfg_i)
			2'h0: half = plld_pkg::RO_HALF_0;
			2'h1: half = plld_pkg::RO_HALF_1;
			2'h2: half = plld_pkg::RO_HALF_2;
			2'h3: half = plld_pkg::RO_HALF_3;
		endcase
		cnt_next = cnt_reg;
		osc_next = osc_reg;
		tick_next = 1'b0;
		if (!run_i) begin
			cnt_next = plld_pkg::RO_CNT_ZERO;
			osc_next = 1'b0;
		end else if (cnt_reg + plld_pkg::RO_CNT_ONE >= half) begin
			cnt_next = plld_pkg::RO_CNT_ZERO;
			osc_next = ~osc_reg;
			tick_next = osc_reg;
		end else begin
			cnt_next = cnt_reg + plld_pkg::RO_CNT_ONE;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cnt_reg <= plld_pkg::RO_CNT_ZERO;
			osc_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			osc_reg <= osc_next;
			tick_reg <= tick_next;
		end
	end

	assign osc_o = osc_reg;
	assign tick_o = tick_reg;
endmodule : plld_ring_osc

// ==== testbench/plld_props.sv ====
// Checker for the lock detector ports: pump masking, lock flag and pin muxes.
// Assumes it is bound onto plld_top and shares its clock and reset.
`timescale 1ns/10ps
module plld_props (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire plld_pkg::plld_cfg_type cfg_i,
	input wire logic ref_edge_i,
	input wire logic vco_edge_i,
	input wire logic pfd_up_i,
	input wire logic pfd_dn_i,
	input wire logic serial_read_i,
	input wire logic serial_data_i,
	input wire logic aux_two_other_i,
	input wire logic pump_up_o,
	input wire logic pump_dn_o,
	input wire logic pump_hiz_o,
	input wire logic locked_flag_o,
	input wire logic lock_or_readback_pin_o,
	input wire logic aux_output_pin_two_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	// Pump outputs follow the detector one cycle later, gated by the enables
	AST_PUMP_UP: assert property (
		!$past(srst_i) |-> pump_up_o == $past(pfd_up_i && cfg_i.up_en)) else $error("pump up wrong");
	AST_PUMP_DN: assert property (
		!$past(srst_i) |-> pump_dn_o == $past(pfd_dn_i && cfg_i.dn_en)) else $error("pump dn wrong");
	AST_PUMP_HIZ: assert property (
		!$past(srst_i) |-> pump_hiz_o == $past(!cfg_i.up_en && !cfg_i.dn_en))
		else $error("pump hiz wrong");
	// Flag held low while detection is off or the ring test runs
	AST_NO_DET: assert property (
		!cfg_i.lock_det_en |=> !locked_flag_o) else $error("flag set while disabled");
	AST_TEST_NO_DET: assert property (
		cfg_i.ro_test |=> !locked_flag_o) else $error("flag set in ring test");
	// Shared pin; a steady flag makes the check blind to flag pipeline depth
	AST_PIN_FORCE: assert property (
		!$past(srst_i) && $past(cfg_i.lock_pin_force) && locked_flag_o == $past(locked_flag_o)
		|-> lock_or_readback_pin_o == locked_flag_o) else $error("forced pin wrong");
	AST_PIN_SHARE: assert property (
		!$past(srst_i) && $past(!cfg_i.lock_pin_force && cfg_i.lock_pin_share && !serial_read_i)
		&& locked_flag_o == $past(locked_flag_o) |-> lock_or_readback_pin_o == locked_flag_o)
		else $error("shared pin wrong");
	AST_PIN_SDO: assert property (
		!$past(srst_i) && $past(!cfg_i.lock_pin_force && (!cfg_i.lock_pin_share || serial_read_i))
		|-> lock_or_readback_pin_o == $past(serial_data_i)) else $error("readback pin wrong");
	AST_AUX_OTHER: assert property (
		!$past(srst_i) && $past(!(cfg_i.ro_test && cfg_i.out_sel == plld_pkg::OUT_SEL_AUX_OSC))
		|-> aux_output_pin_two_o == $past(aux_two_other_i)) else $error("aux pin wrong");
endmodule : plld_props

bind plld_top plld_props plld_props_inst (.ref_clk_i, .srst_i, .cfg_i, .ref_edge_i, .vco_edge_i,
	.pfd_up_i, .pfd_dn_i, .serial_read_i, .serial_data_i, .aux_two_other_i, .pump_up_o,
	.pump_dn_o, .pump_hiz_o, .locked_flag_o, .lock_or_readback_pin_o, .aux_output_pin_two_o);

// ==== testbench/plld_edge_gen.sv ====
// Edge source for the reference and divided VCO pins of the lock detector.
// Assumes one clock; the VCO pulse trails the reference by lag_i cycles.
`timescale 1ns/10ps
module plld_edge_gen (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic [4:0] lag_i,
	output logic ref_edge_o,
	output logic vco_edge_o
);
	logic [4:0] phase_reg;
	logic [4:0] vco_phase;
	// Period of 24 cycles; high 6, low 18 so the synchroniser sees each level
	always_ff @(posedge ref_clk_i) begin
		phase_reg <= (srst_i || phase_reg == 5'h17) ? 5'h00 : phase_reg + 5'h01;
	end
	// One VCO pulse per reference pulse, never two of a kind in a row
	assign vco_phase = (phase_reg >= lag_i) ? phase_reg - lag_i : phase_reg + 5'h18 - lag_i;
	assign ref_edge_o = phase_reg < 5'h06;
	assign vco_edge_o = vco_phase < 5'h06;
endmodule : plld_edge_gen

// ==== testbench/test_plld_top.sv ====
// Self-checking bench for plld_top with a pin edge source.
// Assumes a 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_plld_top;
	logic ref_clk_i, srst_i, pfd_up_i, pfd_dn_i, serial_read_i, serial_data_i, aux_two_other_i;
	logic ref_edge_i, vco_edge_i, pump_up_o, pump_dn_o, pump_hiz_o, locked_flag_o;
	logic lock_or_readback_pin_o, aux_output_pin_two_o, last_aux;
	plld_pkg::plld_cfg_type cfg_i;
	logic [4:0] lag;
	int bad_count = 0;
	int samples_checked = 0;
	int n;
	// Rows: up_en dn_en up dn force share read sdata, then up dn hiz pin
	logic [11:0] rows [6] = '{12'he19, 12'hd64, 12'h754, 12'hbb8, 12'h333, 12'h002};

	plld_top plld_top_inst (.ref_clk_i, .srst_i, .cfg_i, .ref_edge_i, .vco_edge_i, .pfd_up_i,
		.pfd_dn_i, .serial_read_i, .serial_data_i, .aux_two_other_i, .pump_up_o, .pump_dn_o,
		.pump_hiz_o, .locked_flag_o, .lock_or_readback_pin_o, .aux_output_pin_two_o);
	plld_edge_gen plld_edge_gen_inst (.ref_clk_i, .srst_i, .lag_i(lag),
		.ref_edge_o(ref_edge_i), .vco_edge_o(vco_edge_i));

	// Clock
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Inputs move just after the edge so sampling never races
	task tick(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask : tick

	task complete_run;
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	// Watchdog well beyond the roughly 1000 cycles of the run
	initial begin
		#50000;
		bad_count++;
		complete_run();
	end

	// Main sequence
	initial begin
		cfg_i = '0;
		{pfd_up_i, pfd_dn_i, serial_read_i, serial_data_i, aux_two_other_i} = 5'h00;
		lag = 5'h01;
		srst_i = 1'b1;
		tick(4);
		srst_i = 1'b0;
		tick(2);
		`CHK(locked_flag_o, 1'b0)
		for (int i = 0; i < 6; i++) begin
			{cfg_i.up_en, cfg_i.dn_en, pfd_up_i, pfd_dn_i, cfg_i.lock_pin_force,
				cfg_i.lock_pin_share, serial_read_i, serial_data_i} = rows[i][11:4];
			aux_two_other_i = rows[i][4];
			tick(2);
			`CHK({pump_up_o, pump_dn_o, pump_hiz_o}, rows[i][3:1])
			`CHK(lock_or_readback_pin_o, rows[i][0])
			`CHK(aux_output_pin_two_o, rows[i][4])
		end
		// Analog window: three hits needed, then shared pin readback swap
		{cfg_i.lock_pin_force, cfg_i.lock_pin_share, serial_read_i} = 3'h2;
		cfg_i.lock_count = 10'h003;
		cfg_i.lock_det_en = 1'b1;
		tick(40);
		`CHK(locked_flag_o, 1'b0)
		tick(80);
		`CHK(locked_flag_o, 1'b1)
		`CHK(lock_or_readback_pin_o, 1'b1)
		serial_read_i = 1'b1;
		serial_data_i = 1'b0;
		tick(2);
		`CHK(lock_or_readback_pin_o, 1'b0)
		serial_read_i = 1'b0;
		tick(2);
		`CHK(lock_or_readback_pin_o, 1'b1)
		// Two-cycle lag lies outside the one-cycle analog window
		lag = 5'h02;
		tick(30);
		`CHK(locked_flag_o, 1'b0)
		lag = 5'h01;
		tick(120);
		`CHK(locked_flag_o, 1'b1)
		cfg_i.lock_det_en = 1'b0;
		tick(2);
		`CHK(locked_flag_o, 1'b0)
		cfg_i.lock_det_en = 1'b1;
		tick(40);
		`CHK(locked_flag_o, 1'b0)
		// Digital window accepts a lag that analog refuses
		cfg_i.win_digital = 1'b1;
		lag = 5'h03;
		tick(150);
		`CHK(locked_flag_o, 1'b1)
		lag = 5'h0a;
		tick(60);
		`CHK(locked_flag_o, 1'b0)
		cfg_i.ro_cfg = 2'h1;
		cfg_i.win_dur = 2'h1;
		tick(150);
		`CHK(locked_flag_o, 1'b1)
		// Slowest ring with the shortest count still spans a five-cycle lag
		cfg_i.ro_cfg = 2'h3;
		cfg_i.win_dur = 2'h0;
		lag = 5'h05;
		tick(150);
		`CHK(locked_flag_o, 1'b1)
		// Fastest ring refuses it; the longest count then takes a ten-cycle lag
		cfg_i.ro_cfg = 2'h0;
		tick(60);
		`CHK(locked_flag_o, 1'b0)
		cfg_i.win_dur = 2'h3;
		lag = 5'h0a;
		tick(150);
		`CHK(locked_flag_o, 1'b1)
		// Ring test: detection stops and the oscillator reaches aux pin two
		cfg_i.ro_test = 1'b1;
		cfg_i.out_sel = plld_pkg::OUT_SEL_AUX_OSC;
		tick(2);
		`CHK(locked_flag_o, 1'b0)
		n = 0;
		repeat (16) begin
			last_aux = aux_output_pin_two_o;
			tick(1);
			if (aux_output_pin_two_o !== last_aux)
				n++;
		end
		`CHK(n > 3, 1'b1)
		// Test bit without the ring select leaves aux pin two on its normal source
		cfg_i.out_sel = 4'h6;
		aux_two_other_i = 1'b1;
		tick(2);
		`CHK(aux_output_pin_two_o, 1'b1)
		aux_two_other_i = 1'b0;
		tick(2);
		`CHK(aux_output_pin_two_o, 1'b0)
		// Reset in mid-run clears the pump, flag and shared pin outputs, even with an unmasked up pulse
		cfg_i.up_en = 1'b1;
		pfd_up_i = 1'b1;
		srst_i = 1'b1;
		tick(2);
		`CHK({pump_up_o, pump_dn_o, pump_hiz_o, locked_flag_o, lock_or_readback_pin_o}, 5'h00)
		srst_i = 1'b0;
		tick(2);
		`CHK(pump_up_o, 1'b1)
		`CHK(locked_flag_o, 1'b0)
		tick(2);
		complete_run();
	end
endmodule : test_plld_top
